/* design/svfc_pkg.sv */
// Shared constants and carriers for the synchronous pulse-rate converter.
// Assumes one master clock at 10 MHz and a 32-bit AHB-Lite register bus.
package svfc_pkg;

  // ----------------------------------------------------------------
  // Converter scaling
  // ----------------------------------------------------------------
  localparam int ADC_W = 16;
  localparam int FRAC_W = 16;
  // Input code that stands for the reference voltage
  localparam logic signed [18:0] VREF_CODE = 19'sh04000;
  localparam logic signed [18:0] NUM_ZERO = 19'sh00000;
  // Accumulator unity: one output pulse per wrap
  localparam logic [16:0] ACC_ONE = 17'h10000;
  // 0.05 of unity, rounded: zero-scale pulse rate
  localparam logic [15:0] ZS_INC = 16'h0ccd;
  // 0.40 of unity, rounded down: span between zero and full scale
  localparam logic [15:0] SPAN_INC = 16'h6666;
  localparam logic [FRAC_W-1:0] FRAC_MAX = 16'hffff;

  // ----------------------------------------------------------------
  // Settling, in master clock cycles
  // ----------------------------------------------------------------
  localparam int SETTLE_CYC = 2;
  localparam int SETTLE_W = 4;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_INPUT = 8'h0c;
  localparam int CTRL_SOFT_PD = 0;
  localparam int CTRL_COUNT_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_DOWN = 2'h0,
    ST_SETTLE = 2'h1,
    ST_RUN = 2'h3
  } svfc_state_t;

  // Pin group, all from outside the clock domain
  typedef struct packed
  {
    logic chanSelHi;
    logic chanSelLo;
    logic polaritySel;
    logic gainSel;
    logic powerDownN;
  } svfc_pins_t;

  typedef struct packed
  {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } svfc_ahb_req_t;

  typedef struct packed
  {
    logic [31:0] hrdata;
    logic hreadyout;
    logic [1:0] hresp;
  } svfc_ahb_rsp_t;

endpackage

/* design/svfc_span_sel.sv */
// Input pair selection and span scaling for the modulator.
// Assumes input words are sampled on the same clock; output is registered.
`timescale 1ns/1ps
module svfc_span_sel
  import svfc_pkg::*;
#(
  parameter int W = ADC_W
)
(
  input wire logic clock, // Master clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [1:0] chanSel, // Channel select, hi then lo
  input wire logic polaritySel, // 1 unipolar, 0 bipolar
  input wire logic gainSel, // 1 gain of two
  input wire logic signed [W-1:0] analogIn1, // Input word 1
  input wire logic signed [W-1:0] analogIn2, // Input word 2
  input wire logic signed [W-1:0] analogIn3, // Input word 3
  input wire logic signed [W-1:0] analogIn4, // Input word 4
  output logic [FRAC_W-1:0] inputFrac // Position within span, 0..1
);
  // ----------------------------------------------------------------
  // Pair selection
  // ----------------------------------------------------------------
  // (R1) pair routing
  wire logic signed [W-1:0] posIn = (chanSel == 2'h2) ? analogIn3 :
                                    (chanSel == 2'h1) ? analogIn2 : analogIn1;
  wire logic signed [W-1:0] negIn = (chanSel == 2'h3) ? analogIn2 : analogIn4;
  // Both sides sign-extended first, so negative and full-range words subtract right
  wire logic signed [W:0] diff = (W+1)'(posIn) - (W+1)'(negIn);

  // ----------------------------------------------------------------
  // Span scaling
  // ----------------------------------------------------------------
  // (R2) gain and polarity span
  wire logic signed [18:0] scaled = gainSel ? (19'(diff) <<< 1) : 19'(diff);
  wire logic signed [18:0] num = polaritySel ? scaled : scaled + VREF_CODE;
  // Bipolar span is twice the reference, unipolar once
  wire logic signed [18:0] den = polaritySel ? VREF_CODE : (VREF_CODE <<< 1);
  wire logic [FRAC_W-1:0] fracBip = {num[14:0], 1'b0};
  wire logic [FRAC_W-1:0] fracUni = {num[13:0], 2'b0};
  wire logic isLow = (num < NUM_ZERO);
  wire logic isHigh = (num >= den);
  wire logic [FRAC_W-1:0] frac = isLow ? '0 : isHigh ? FRAC_MAX :
                                 polaritySel ? fracUni : fracBip;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      inputFrac <= '0;
    else
      inputFrac <= frac;
  end

endmodule

/* design/svfc_top.sv */
// Synchronous voltage-to-frequency converter, digital side.
// Assumes input words arrive already sampled on clock, which is the master
// clock; pins arrive asynchronously and are synchronised here.
//
// How it works
// (R1) Channel select 00,01,10,11 picks 1-4, 2-4, 3-4, 1-2 as input pair.
// (R2) Polarity and gain pins pick bipolar or unipolar span, gain one or two.
// (R3) Full scale gives 0.45 clock rate, zero scale 0.05 clock rate.
// (R4) Between limits rate follows input; pulse width stays fixed.
// (R5) Every output pulse lasts exactly the clock high phase.
// (R6) Every output pulse starts on a clock rising edge.
// (R7) Output counts as valid only after settling cycles following power-up or step.
// (R8) Modulator samples the scaled input on every master clock cycle.
// (R9) Comparator decision feeds one-bit feedback and forms the pulse train.
// (R10) Power-down pin low stops conversion; high lets it run. Here the soft power-down bit in CTRL also stops it, even with the pin high.
// (R11) Powered down holds output low; release restarts settling.
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module svfc_top
  import svfc_pkg::*;
#(
  parameter int W = ADC_W,
  parameter int SETTLE = SETTLE_CYC
)
(
  input wire logic clock, // Master clock
  input wire logic reset_n, // Async reset, active low
  input wire svfc_pkg::svfc_pins_t pins, // Select and power-down pins
  input wire logic signed [W-1:0] analogIn1, // Input word 1
  input wire logic signed [W-1:0] analogIn2, // Input word 2
  input wire logic signed [W-1:0] analogIn3, // Input word 3
  input wire logic signed [W-1:0] analogIn4, // Input word 4
  input wire svfc_pkg::svfc_ahb_req_t ahbReq, // AHB-Lite request side
  output svfc_pkg::svfc_ahb_rsp_t ahbRsp, // AHB-Lite response side
  output logic freqOut, // Pulse train output
  output logic freqValid // Output has settled
);
  import svfc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int PIN_W = $bits(svfc_pins_t);
  logic [PIN_W-1:0] pinMeta_r;
  logic [PIN_W-1:0] pinSync_r;
  svfc_pins_t pinS;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : g_sync
      always_ff @(posedge clock or negedge reset_n)
      begin
        if (!reset_n)
        begin
          pinMeta_r[gi] <= 1'b0;
          pinSync_r[gi] <= 1'b0;
        end
        else
        begin
          pinMeta_r[gi] <= pins[gi];
          pinSync_r[gi] <= pinMeta_r[gi];
        end
      end
    end
  endgenerate

  assign pinS = svfc_pins_t'(pinSync_r);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  wire logic softPd = ctrl_r[CTRL_SOFT_PD];
  wire logic countEn = ctrl_r[CTRL_COUNT_EN];

  // (R10) pin or software power-down
  wire logic pdActive = !pinS.powerDownN || softPd;

  // ----------------------------------------------------------------
  // Input selection and scaling
  // ----------------------------------------------------------------
  wire logic [1:0] chanSel = {pinS.chanSelHi, pinS.chanSelLo};
  logic [FRAC_W-1:0] inputFrac;

  svfc_span_sel #(
    .W(W)
  ) u_span (
    .clock(clock),
    .reset_n(reset_n),
    .chanSel(chanSel),
    .polaritySel(pinS.polaritySel),
    .gainSel(pinS.gainSel),
    .analogIn1(analogIn1),
    .analogIn2(analogIn2),
    .analogIn3(analogIn3),
    .analogIn4(analogIn4),
    .inputFrac(inputFrac)
  );

  // ----------------------------------------------------------------
  // Settling and power state
  // ----------------------------------------------------------------
  logic [3:0] cfgPrev_r;
  wire logic [3:0] cfgNow = {chanSel, pinS.polaritySel, pinS.gainSel};
  // A setting change is the digital view of an input step
  wire logic cfgStep = (cfgNow != cfgPrev_r);

  svfc_state_t state_r;
  svfc_state_t state_nxt;
  logic [SETTLE_W-1:0] settleCnt_r;
  logic [SETTLE_W-1:0] settleCnt_nxt;
  wire logic settleDone = (settleCnt_r == SETTLE_W'(SETTLE - 1));

  always_comb
  begin
    state_nxt = state_r;
    settleCnt_nxt = settleCnt_r;
    case (state_r)
      ST_DOWN:
      begin
        settleCnt_nxt = '0;
        if (!pdActive)
          state_nxt = ST_SETTLE;
      end
      ST_SETTLE:
      begin
        // (R7) count settling cycles
        if (pdActive)
          state_nxt = ST_DOWN;
        else if (cfgStep)
          settleCnt_nxt = '0;
        else if (settleDone)
          state_nxt = ST_RUN;
        else
          settleCnt_nxt = settleCnt_r + SETTLE_W'(1);
      end
      ST_RUN:
      begin
        settleCnt_nxt = '0;
        // (R11) release goes back through settling
        if (pdActive)
          state_nxt = ST_DOWN;
        else if (cfgStep)
          state_nxt = ST_SETTLE;
      end
      default:
      begin
        state_nxt = ST_DOWN;
        settleCnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_DOWN;
      settleCnt_r <= '0;
      cfgPrev_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      settleCnt_r <= settleCnt_nxt;
      cfgPrev_r <= cfgNow;
    end
  end

  // ----------------------------------------------------------------
  // Charge-balance modulator
  // ----------------------------------------------------------------
  wire logic running = (state_r != ST_DOWN);
  logic [15:0] acc_r;
  // (R3) (R4) rate from 0.05 to 0.45 of the clock
  wire logic [31:0] spanProd = 32'(inputFrac) * 32'(SPAN_INC);
  wire logic [16:0] inc = 17'(ZS_INC) + 17'(spanProd[31:16]);
  // (R8) input integrated every cycle
  wire logic [16:0] sum = 17'(acc_r) + inc;
  // (R9) comparator decision and one-bit feedback
  wire logic fire = running && (sum >= ACC_ONE);
  wire logic [16:0] accNext = fire ? (sum - ACC_ONE) : sum;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      acc_r <= '0;
    else if (!running)
      acc_r <= '0;
    else
      acc_r <= accNext[15:0];
  end

  // ----------------------------------------------------------------
  // Pulse shaping
  // ----------------------------------------------------------------
  // Rising-edge toggle and falling-edge copy differ only during the high
  // phase after a decision; the xor of two flops cannot glitch since only
  // one of them moves at any clock edge.
  logic riseTog_r;
  logic fallTog_r;

  // (R6) pulse begins on the rising edge
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      riseTog_r <= 1'b0;
    else
      riseTog_r <= riseTog_r ^ fire;
  end

  // (R5) pulse ends at the falling edge
  always_ff @(negedge clock or negedge reset_n)
  begin
    if (!reset_n)
      fallTog_r <= 1'b0;
    else
      fallTog_r <= riseTog_r;
  end

  // (R11) no decisions while down, so the output stays low
  assign freqOut = riseTog_r ^ fallTog_r;

  // (R7) valid flag follows settling
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      freqValid <= 1'b0;
    else
      freqValid <= (state_nxt == ST_RUN);
  end

  // ----------------------------------------------------------------
  // Pulse counter
  // ----------------------------------------------------------------
  logic [31:0] count_r;
  logic countClr;
  // A pulse in the clearing cycle is kept
  wire logic [31:0] countBase = countClr ? '0 : count_r;
  wire logic [31:0] count_nxt = countBase + 32'(fire && countEn);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      count_r <= '0;
    else
      count_r <= count_nxt;
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait states: read data is picked up in the address phase and
  // stands in the following data phase.
  wire logic addrPhase = ahbReq.hsel && ahbReq.hready && (ahbReq.htrans == HTRANS_NONSEQ);
  wire logic [7:0] addrByte = ahbReq.haddr[7:0];
  wire logic addrHigh = (ahbReq.haddr[31:8] != '0);
  wire logic rdStart = addrPhase && !ahbReq.hwrite;
  wire logic wrStart = addrPhase && ahbReq.hwrite;

  logic wrPend_r;
  logic [7:0] wrAddr_r;

  wire logic [31:0] statusWord = {26'h0, pinS.gainSel, pinS.polaritySel,
                                  chanSel, (state_r == ST_DOWN), freqValid};
  wire logic selCtrl = !addrHigh && (addrByte == REG_CTRL);
  wire logic selStatus = !addrHigh && (addrByte == REG_STATUS);
  wire logic selCount = !addrHigh && (addrByte == REG_COUNT);
  wire logic selInput = !addrHigh && (addrByte == REG_INPUT);
  // Unmapped addresses read as zero
  wire logic [31:0] rdMux = selCtrl ? {30'h0, ctrl_r} :
                            selStatus ? statusWord :
                            selCount ? count_r :
                            selInput ? {16'h0, inputFrac} : 32'h0;

  wire logic wrCtrl = wrPend_r && (wrAddr_r == REG_CTRL);
  assign countClr = wrPend_r && (wrAddr_r == REG_COUNT);
  assign ctrl_nxt = wrCtrl ? ahbReq.hwdata[1:0] : ctrl_r;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
      ctrl_r <= CTRL_RESET;
    end
    else
    begin
      wrPend_r <= wrStart;
      wrAddr_r <= addrHigh ? 8'hff : addrByte;
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ahbRsp.hrdata <= '0;
      ahbRsp.hreadyout <= 1'b1;
      ahbRsp.hresp <= HRESP_OKAY;
    end
    else
    begin
      if (rdStart)
        ahbRsp.hrdata <= rdMux;
      ahbRsp.hreadyout <= 1'b1;
      ahbRsp.hresp <= HRESP_OKAY;
    end
  end

endmodule

/* bench/svfc_pulse_counter.sv */
// Far-end model: a gated pulse counter on the pulse output.
// Assumes the gate changes just after rising clock edges.
`timescale 1ns/1ps
module svfc_pulse_counter
(
  input wire logic clock, // Master clock, gate timebase
  input wire logic gate, // Count window, high to count
  input wire logic freqOut, // Pulse train from the converter
  output logic [15:0] count // Pulses seen in the last window
);
  logic gateSeen_r;

  // one count per pulse
  // Sampled at the falling edge, the end of the high phase where a pulse stands; clock drift cancels out
  always_ff @(negedge clock)
  begin
    gateSeen_r <= gate;
    if (gate && !gateSeen_r)
      count <= {15'h0, freqOut};
    else if (gate && freqOut)
      count <= count + 16'h1;
  end
endmodule

/* bench/svfc_top_checker.sv */
// Port-level assertions for the converter top.
// Assumes pins change only just after a rising clock edge.
`timescale 1ns/1ps
module svfc_top_checker
  import svfc_pkg::*;
#(
  parameter int W = ADC_W,
  parameter int SETTLE = SETTLE_CYC
)
(
  input wire logic clock, // Master clock
  input wire logic reset_n, // Async reset, active low
  input wire svfc_pkg::svfc_pins_t pins, // Select and power-down pins
  input wire logic signed [W-1:0] analogIn1, // Input word 1
  input wire logic signed [W-1:0] analogIn2, // Input word 2
  input wire logic signed [W-1:0] analogIn3, // Input word 3
  input wire logic signed [W-1:0] analogIn4, // Input word 4
  input wire svfc_pkg::svfc_ahb_req_t ahbReq, // Bus request
  input wire svfc_pkg::svfc_ahb_rsp_t ahbRsp, // Bus response
  input wire logic freqOut, // Pulse train
  input wire logic freqValid // Settled flag
);
  // ----------------------------------------------------------------
  // Cycles the pins have stood still while powered up
  // ----------------------------------------------------------------
  logic [3:0] steadyCnt_r;
  svfc_pins_t pinsPrev_r;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      steadyCnt_r <= 4'h0;
      pinsPrev_r <= '0;
    end
    else
    begin
      pinsPrev_r <= pins;
      if (pins != pinsPrev_r || !pins.powerDownN)
        steadyCnt_r <= 4'h0;
      else if (steadyCnt_r != 4'hf)
        steadyCnt_r <= steadyCnt_r + 4'h1;
    end
  end

  sequence readTaken;
    ahbReq.hsel && ahbReq.hready && ahbReq.htrans == HTRANS_NONSEQ && !ahbReq.hwrite;
  endsequence

  a_low_at_rise: assert property (@(posedge clock) disable iff (!reset_n) !freqOut)
    else $error("pulse output high across a rising edge");
  a_one_phase_only: assert property (@(negedge clock) disable iff (!reset_n) freqOut |=> !freqOut)
    else $error("pulse output high in two cycles running");
  a_zero_scale_gap: assert property (@(negedge clock) disable iff (!reset_n)
    freqValid && freqOut |-> ##[1:20] (freqOut || !freqValid))
    else $error("pulse gap longer than zero-scale rate allows");
  a_down_quiet: assert property (@(negedge clock) disable iff (!reset_n)
    !pins.powerDownN [*5] |-> !freqOut && !freqValid)
    else $error("output active while powered down");
  a_valid_settled: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(freqValid) |-> steadyCnt_r >= SETTLE)
    else $error("valid raised before settling");
  a_valid_needs_pin: assert property (@(posedge clock) disable iff (!reset_n)
    freqValid |-> $past(pins.powerDownN, 4))
    else $error("valid while power-down pin low");
  a_resp_okay: assert property (@(posedge clock) disable iff (!reset_n)
    ahbRsp.hreadyout && ahbRsp.hresp == HRESP_OKAY)
    else $error("bus answer not ready or not okay");
  a_unmapped_zero: assert property (@(posedge clock) disable iff (!reset_n)
    readTaken ##0 ahbReq.haddr[31:4] != 28'h0 |=> ahbRsp.hrdata == 32'h0)
    else $error("unmapped read returned nonzero");
  a_status_pins: assert property (@(posedge clock) disable iff (!reset_n)
    readTaken ##0 (ahbReq.haddr == {24'h0, REG_STATUS} && steadyCnt_r >= 4'h3)
    |=> ahbRsp.hrdata[5:2] == $past({pins.gainSel, pins.polaritySel, pins.chanSelHi,
    pins.chanSelLo}))
    else $error("status does not show the pin settings");
endmodule

bind svfc_top svfc_top_checker #(.W(W), .SETTLE(SETTLE)) svfc_top_checker_i (.clock(clock),
  .reset_n(reset_n), .pins(pins), .analogIn1(analogIn1), .analogIn2(analogIn2),
  .analogIn3(analogIn3), .analogIn4(analogIn4), .ahbReq(ahbReq), .ahbRsp(ahbRsp),
  .freqOut(freqOut), .freqValid(freqValid));

/* bench/svfc_top_tb.sv */
// Self-checking bench for the converter top and a gated pulse counter.
// Assumes the design package is compiled first; bench is the only bus master.
`timescale 1ns/1ps
module svfc_top_tb;
  import svfc_pkg::*;
  logic clock;
  logic reset_n;
  logic gate;
  svfc_pins_t pins;
  logic signed [15:0] in1, in2, in3, in4;
  svfc_ahb_req_t req;
  svfc_ahb_req_t busReq;
  svfc_ahb_rsp_t ahbRsp;
  logic freqOut;
  logic freqValid;
  logic [15:0] count;
  logic [31:0] rd;
  int nMismatch;
  int comparisons;
  // Mode {chanSel, polarity, gain} and pulses per 1000 cycles
  logic [3:0] modes [8] = '{4'h2, 4'h6, 4'ha, 4'he, 4'h0, 4'h1, 4'hb, 4'hd};
  int rates [8] = '{150, 250, 350, 50, 300, 350, 450, 150};
  // Span fraction each mode must show in the input register
  logic [15:0] fracs [8] = '{16'h4000, 16'h8000, 16'hc000, 16'h0000, 16'ha000, 16'hc000,
    16'hffff, 16'h4000};

  assign busReq = '{req.hsel, req.haddr, req.htrans, req.hwrite, req.hsize, req.hwdata,
    ahbRsp.hreadyout};

  svfc_top #(.W(16), .SETTLE(SETTLE_CYC)) svfc_top_i (.clock(clock), .reset_n(reset_n),
    .pins(pins), .analogIn1(in1), .analogIn2(in2), .analogIn3(in3), .analogIn4(in4),
    .ahbReq(busReq), .ahbRsp(ahbRsp), .freqOut(freqOut), .freqValid(freqValid));
  svfc_pulse_counter svfc_pulse_counter_i (.clock(clock), .gate(gate), .freqOut(freqOut),
    .count(count));

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
    comparisons++;
    if ((got + tol >= exp && got <= exp + tol) !== 1'b1)
    begin
      nMismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Single-word bus transfer; waits on ready in both phases
  // ----------------------------------------------------------------
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    req <= '{1'b1, {24'h0, a}, HTRANS_NONSEQ, wr, 3'h2, req.hwdata, 1'b1};
    @(posedge clock);
    while (ahbRsp.hreadyout !== 1'b1)
      @(posedge clock);
    req <= '{1'b1, req.haddr, 2'h0, wr, 3'h2, wd, 1'b1};
    @(posedge clock);
    while (ahbRsp.hreadyout !== 1'b1)
      @(posedge clock);
    rd = ahbRsp.hrdata;
  endtask

  task automatic waitLevel(input logic lvl);
    int n;
    n = 0;
    while (freqValid !== lvl && n < 12)
    begin
      @(posedge clock);
      n++;
    end
    check({31'h0, freqValid}, {31'h0, lvl}, 0);
  endtask

  // Counts over 1000 cycles, in the far-end counter and in the count register
  task automatic measure(input int exp, input int tol);
    ahb(1'b1, REG_COUNT, 32'h0);
    gate <= 1'b1;
    repeat (1000) @(posedge clock);
    gate <= 1'b0;
    ahb(1'b0, REG_COUNT, 32'h0);
    check(rd, exp, tol + 3);
    check({16'h0, count}, exp, tol);
  endtask

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // About 12k cycles expected
  initial
  begin
    #3000000;
    nMismatch++;
    results();
  end

  initial
  begin
    reset_n = 1'b0;
    gate = 1'b0;
    pins = 5'h01;
    in1 = 16'sh1000;
    in2 = 16'sh2000;
    in3 = 16'sh3000;
    in4 = 16'sh0000;
    req = '0;
    nMismatch = 0;
    comparisons = 0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    ahb(1'b0, REG_CTRL, 32'h0);
    check(rd, {30'h0, CTRL_RESET}, 0);
    ahb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0, 0);
    waitLevel(1'b1);
    for (int i = 0; i < 8; i++)
    begin
      pins <= {modes[i], 1'b1};
      @(posedge clock);
      waitLevel(1'b0);
      waitLevel(1'b1);
      ahb(1'b0, REG_STATUS, 32'h0);
      check(rd, {26'h0, modes[i][0], modes[i][1], modes[i][3:2], 2'b01}, 0);
      ahb(1'b0, REG_INPUT, 32'h0);
      check(rd, {16'h0, fracs[i]}, 0);
      measure(rates[i], 2);
    end
    pins <= 5'h00;
    waitLevel(1'b0);
    measure(0, 0);
    ahb(1'b0, REG_STATUS, 32'h0);
    check({30'h0, rd[1:0]}, 32'h2, 0);
    pins <= 5'h01;
    waitLevel(1'b1);
    ahb(1'b1, REG_CTRL, 32'h3);
    waitLevel(1'b0);
    measure(0, 0);
    ahb(1'b1, REG_CTRL, {30'h0, CTRL_RESET});
    waitLevel(1'b1);
    measure(300, 2);
    // Counting off while still converting: register must stay cleared
    ahb(1'b1, REG_CTRL, 32'h0);
    ahb(1'b1, REG_COUNT, 32'h0);
    repeat (100) @(posedge clock);
    waitLevel(1'b1);
    ahb(1'b0, REG_COUNT, 32'h0);
    check(rd, 32'h0, 0);
    results();
  end
endmodule
